//--- shared/isf_pkg.sv
package isf_pkg;
   // register offsets, printed byte addresses
   localparam logic [6:0] OFS_GYRO  = 7'h04;
   localparam logic [6:0] OFS_ACCEL = 7'h0A;
   localparam logic [6:0] OFS_MAG   = 7'h10;
   localparam logic [6:0] OFS_BARO  = 7'h16;
   localparam logic [6:0] OFS_TEMP  = 7'h18;
   localparam logic [6:0] OFS_BIAS  = 7'h1A;
   localparam logic [6:0] OFS_GPIO  = 7'h32;
   localparam logic [6:0] OFS_MISC  = 7'h34;
   localparam logic [6:0] OFS_SMPL  = 7'h36;
   localparam logic [6:0] OFS_AVG   = 7'h38;
   localparam logic [6:0] OFS_SEQ   = 7'h3A;
   localparam logic [6:0] OFS_STEP  = 7'h02;  // axis spacing

   // reset values
   localparam logic [15:0] RST_GPIO = 16'h0000;
   localparam logic [15:0] RST_MISC = 16'h0006;
   localparam logic [15:0] RST_SMPL = 16'h0001;
   localparam logic [15:0] RST_AVG  = 16'h0402;

   // bits that exist; the rest read zero
   localparam logic [15:0] MASK_GPIO = 16'h0F0F;
   localparam logic [15:0] MASK_MISC = 16'h0007;
   localparam logic [15:0] MASK_SMPL = 16'h1F01;
   localparam logic [15:0] MASK_AVG  = 16'h0707;

   // field positions
   localparam int GPIO_LVL_LSB = 8;
   localparam int SMPL_CLK_BIT = 0;
   localparam int SMPL_DEC_LSB = 8;
   localparam int AVG_B_LSB    = 0;
   localparam int AVG_RNG_LSB  = 8;
   localparam int MISC_DR_EN   = 2;
   localparam int MISC_DR_POL  = 1;
   localparam int MISC_DR_SEL  = 0;

   // gyro range codes and their least filter size
   localparam logic [2:0] RANGE_1000 = 3'h4;
   localparam logic [2:0] RANGE_500  = 3'h2;
   localparam logic [2:0] RANGE_250  = 3'h1;
   localparam logic [2:0] MIN_B_500  = 3'h2;
   localparam logic [2:0] MIN_B_250  = 3'h4;

   // slow sensor cadence
   localparam logic [6:0] SLOW_DIV   = 7'h10;
   localparam logic [6:0] SEQ_LAST   = 7'h01;
   localparam logic [4:0] SLOW_MAX_D = 5'h04;

   // timing
   localparam longint unsigned CLK_HZ        = 64'd100000000;
   localparam longint unsigned INT_RATE_MSPS = 64'd819200;
   localparam int unsigned SAMPLE_CYC =
      int'((CLK_HZ * 64'd1000) / INT_RATE_MSPS);
   localparam int unsigned CLK_PERIOD_NS = int'(64'd1000000000 / CLK_HZ);
   localparam int unsigned DRDY_INVALID_NS  = 200;
   localparam int unsigned DRDY_INVALID_CYC =
      (DRDY_INVALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [6:0]  addr;
      logic [15:0] wdata;
   } isf_reg_req_t;

   typedef struct packed {
      logic [2:0][15:0] gyro;
      logic [2:0][15:0] accel;
      logic [15:0]      temp;
   } isf_inertial_t;

   typedef struct packed {
      logic [2:0][15:0] mag;
      logic [15:0]      baro;
   } isf_slow_t;

   typedef struct packed {
      logic [3:0] out;
      logic [3:0] oe;
   } isf_pin_t;
endpackage : isf_pkg

//--- verilog/isf_boxcar.sv
`timescale 1ns/1ps
module isf_boxcar #(
   parameter int W    = 16,
   parameter int MAXB = 7
) (
   // clock and reset
   input  wire logic                mclk,
   input  wire logic                srst,
   // control
   input  wire logic                clr,
   input  wire logic                en,
   input  wire logic [2:0]          taps_log2,
   // data
   input  wire logic signed [W-1:0] din,
   output wire logic signed [W-1:0] dout
);
   localparam int DEPTH = 1 << MAXB;
   localparam int SW    = W + MAXB + 1;

   logic [DEPTH-1:0][W-1:0] hist;
   logic signed [SW-1:0]    sum;
   logic [MAXB-1:0]         old_idx;
   logic signed [W-1:0]     oldest;

   assign old_idx = MAXB'((1 << taps_log2) - 1);
   assign oldest  = hist[old_idx];

   // running sum: add newest, drop the one leaving the window
   always_ff @(posedge mclk) begin
      if (srst || clr) begin
         hist <= '0;
         sum  <= '0;
      end else if (en) begin
         hist <= {hist[DEPTH-2:0], din};
         sum  <= sum + SW'(din) - SW'(oldest);
      end
   end

   // mean of the window; arithmetic shift keeps sign
   assign dout = W'(sum >>> taps_log2);
endmodule : isf_boxcar

//--- verilog/isf_filter_io.sv
`timescale 1ns/1ps
// Contract
// - data ready owns its line first
// - alarm outranks gpio on lines one, two
// - external clock makes line four input
// - gpio governs free lines, always line three
// - bits 11..8 are line levels
// - bits 3..0 are directions, one output
// - internal rate 819.2 samples per second
// - each D step halves update rate
// - temperature decimated like inertial outputs
// - clock select bit, reset 0x0001
// - two cascaded averagers, 2^B taps each
// - range code sets least filter size
// - slow sensors every 16 samples
// - slow rate follows D only above 4
// - new-data flag set on load, read clears
// - sequence counts 16 down to 1, reloads
// - sequence span 16/2^D for D 1..4
// - gyro bias added before output register
// - gpio register resets to zero
// - data ready defaults on line one, high
module isf_filter_io #(
   parameter int unsigned SAMPLE_CYC_P = isf_pkg::SAMPLE_CYC,
   parameter int          MAXB         = 7
) (
   // clock and reset
   input  wire logic                   mclk,
   input  wire logic                   srst,
   // register access
   input  wire isf_pkg::isf_reg_req_t  reg_req,
   output logic [15:0]                 reg_rdata,
   // sensor samples
   input  wire isf_pkg::isf_inertial_t inertial_in,
   input  wire isf_pkg::isf_slow_t     slow_in,
   // alarm indicator requests
   input  wire logic [1:0]             alarm_drive,
   input  wire logic [1:0]             alarm_level,
   // io lines
   input  wire logic                   io_line_one_in,
   input  wire logic                   io_line_two_in,
   input  wire logic                   io_line_three_in,
   input  wire logic                   io_line_four_in,
   output isf_pkg::isf_pin_t           io_pins,
   // status
   output logic                        mag_new_data,
   output logic                        out_update
);
   import isf_pkg::*;

   logic [15:0]      general_io_control;
   logic [15:0]      misc_control_reg;
   logic [15:0]      sample_period_control;
   logic [15:0]      filter_and_range_control;
   logic [15:0]      gyro_x_bias_correction;
   logic [15:0]      gyro_y_bias_correction;
   logic [15:0]      gyro_z_bias_correction;
   logic [2:0][15:0] gyro_output_regs;
   logic [2:0][15:0] accel_output_regs;
   logic [2:0][15:0] magnetometer_output_regs;
   logic [15:0]      pressure_output_reg;
   logic [15:0]      temp_output_reg;
   logic [6:0]       slow_sensor_sequence_counter;

   logic [3:0]       pin_meta;
   logic [3:0]       pin_sync;
   logic [3:0]       pin_prev;
   logic [31:0]      div_cnt;
   logic             clk_int;
   logic             tick;
   logic [2:0]       tick_d;
   logic [6:0][15:0] raw_q;
   logic [6:0][15:0] s1_out;
   logic [6:0][15:0] s2_out;
   logic [6:0][15:0] mean;
   logic [4:0]       dec_d;
   logic [31:0]      dec_cnt;
   logic             dec_last;
   logic             dec_fire;
   logic             smpl_wr;
   logic             avg_wr;
   logic [6:0]       seq_reload;
   logic             mag_load;
   logic             slow_rd;
   logic [15:0]      rd_val;
   logic [15:0]      inv_cnt;
   logic             drdy_valid;
   logic             dr_lvl;
   logic [3:0]       gpio_dir;
   logic [3:0]       gpio_lvl;
   logic [3:0]       lvl_rd;
   logic [2:0][15:0] gyro_bias;

   assign clk_int  = sample_period_control[SMPL_CLK_BIT];
   assign dec_d    = sample_period_control[SMPL_DEC_LSB +: 5];
   assign gpio_dir = general_io_control[3:0];
   assign gpio_lvl = general_io_control[GPIO_LVL_LSB +: 4];
   assign smpl_wr  = reg_req.wr && (reg_req.addr == OFS_SMPL);
   assign avg_wr   = reg_req.wr && (reg_req.addr == OFS_AVG);
   assign gyro_bias = {gyro_z_bias_correction, gyro_y_bias_correction,
                       gyro_x_bias_correction};

   // filter word with the range-driven floor on the tap count
   function automatic logic [15:0] clamp_avg(input logic [15:0] w);
      logic [15:0] r;
      r = w & MASK_AVG;
      if (r[AVG_RNG_LSB +: 3] == RANGE_250 && r[AVG_B_LSB +: 3] < MIN_B_250)
         r[AVG_B_LSB +: 3] = MIN_B_250;
      if (r[AVG_RNG_LSB +: 3] == RANGE_500 && r[AVG_B_LSB +: 3] < MIN_B_500)
         r[AVG_B_LSB +: 3] = MIN_B_500;
      return r;
   endfunction : clamp_avg

   // pins are asynchronous; stage one feeds only stage two
   always_ff @(posedge mclk) begin
      if (srst) begin
         pin_meta <= '0;
         pin_sync <= '0;
         pin_prev <= '0;
      end else begin
         pin_meta <= {io_line_four_in, io_line_three_in,
                      io_line_two_in, io_line_one_in};
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   // config registers
   // gpio reset zero
   always_ff @(posedge mclk) begin
      if (srst) begin
         general_io_control       <= RST_GPIO;
         misc_control_reg         <= RST_MISC;
         sample_period_control    <= RST_SMPL;
         filter_and_range_control <= RST_AVG;
      end else if (reg_req.wr) begin
         if (reg_req.addr == OFS_GPIO)
            general_io_control <= reg_req.wdata & MASK_GPIO;
         if (reg_req.addr == OFS_MISC)
            misc_control_reg <= reg_req.wdata & MASK_MISC;
         if (smpl_wr)
            sample_period_control <= reg_req.wdata & MASK_SMPL;
         if (avg_wr)
            filter_and_range_control <= clamp_avg(reg_req.wdata);
      end
   end

   // bias correction registers
   always_ff @(posedge mclk) begin
      if (srst) begin
         gyro_x_bias_correction <= 16'h0000;
         gyro_y_bias_correction <= 16'h0000;
         gyro_z_bias_correction <= 16'h0000;
      end else if (reg_req.wr) begin
         if (reg_req.addr == OFS_BIAS)
            gyro_x_bias_correction <= reg_req.wdata;
         if (reg_req.addr == OFS_BIAS + OFS_STEP)
            gyro_y_bias_correction <= reg_req.wdata;
         if (reg_req.addr == OFS_BIAS + OFS_STEP + OFS_STEP)
            gyro_z_bias_correction <= reg_req.wdata;
      end
   end

   // internal sample divider, idle while external clock is chosen
   // internal sample rate
   always_ff @(posedge mclk) begin
      if (srst || !clk_int)
         div_cnt <= '0;
      else if (div_cnt == 32'(SAMPLE_CYC_P - 1))
         div_cnt <= '0;
      else
         div_cnt <= div_cnt + 32'h0000_0001;
   end

   assign tick = clk_int ? (div_cnt == 32'(SAMPLE_CYC_P - 1))
                         : (pin_sync[3] && !pin_prev[3]);

   // sample capture and stage strobes
   always_ff @(posedge mclk) begin
      if (srst) begin
         tick_d <= '0;
         raw_q  <= '0;
      end else begin
         tick_d <= {tick_d[1:0], tick};
         if (tick)
            raw_q <= {inertial_in.gyro, inertial_in.accel, inertial_in.temp};
      end
   end

   // two cascaded averagers per inertial channel, temperature bypasses
   // bartlett cascade
   genvar ch;
   generate
      for (ch = 0; ch < 7; ch++) begin : g_chan
         logic signed [47:0] acc;
         logic signed [47:0] sum_now;
         if (ch == 0) begin : g_temp
            assign s1_out[ch] = raw_q[ch];
            assign s2_out[ch] = raw_q[ch];
         end else begin : g_filt
            isf_boxcar #(.W(16), .MAXB(MAXB)) u_stage1 (
               .mclk      (mclk),
               .srst      (srst),
               .clr       (avg_wr),
               .en        (tick_d[0]),
               .taps_log2 (filter_and_range_control[AVG_B_LSB +: 3]),
               .din       (raw_q[ch]),
               .dout      (s1_out[ch])
            );
            isf_boxcar #(.W(16), .MAXB(MAXB)) u_stage2 (
               .mclk      (mclk),
               .srst      (srst),
               .clr       (avg_wr),
               .en        (tick_d[1]),
               .taps_log2 (filter_and_range_control[AVG_B_LSB +: 3]),
               .din       (s1_out[ch]),
               .dout      (s2_out[ch])
            );
         end
         assign sum_now = acc + 48'(signed'(s2_out[ch]));
         always_ff @(posedge mclk) begin
            if (srst || smpl_wr)
               acc <= '0;
            else if (tick_d[2])
               acc <= dec_last ? '0 : sum_now;
         end
         assign mean[ch] = 16'(sum_now >>> dec_d);
      end
   endgenerate

   // decimation counter; a new D restarts the average cleanly
   // boxcar decimation
   assign dec_last = dec_cnt == ((32'h0000_0001 << dec_d) - 32'h0000_0001);
   assign dec_fire = tick_d[2] && dec_last;
   always_ff @(posedge mclk) begin
      if (srst || smpl_wr)
         dec_cnt <= '0;
      else if (tick_d[2])
         dec_cnt <= dec_last ? '0 : dec_cnt + 32'h0000_0001;
   end

   // output registers, channel 0 is temperature
   // temperature decimated too
   always_ff @(posedge mclk) begin
      if (srst) begin
         gyro_output_regs  <= '0;
         accel_output_regs <= '0;
         temp_output_reg   <= 16'h0000;
         out_update        <= 1'b0;
      end else begin
         out_update <= dec_fire;
         if (dec_fire) begin
            temp_output_reg <= mean[0];
            for (int i = 0; i < 3; i++) begin
               gyro_output_regs[i]  <= mean[4 + i] + gyro_bias[i];
               accel_output_regs[i] <= mean[1 + i];
            end
         end
      end
   end

   // slow sensor cadence tied to the sequence counter
   // decimation above four
   assign seq_reload = (dec_d <= SLOW_MAX_D) ? (SLOW_DIV >> dec_d)
                                            : SEQ_LAST;
   assign mag_load = out_update && (slow_sensor_sequence_counter <= SEQ_LAST);

   always_ff @(posedge mclk) begin
      if (srst)
         slow_sensor_sequence_counter <= SLOW_DIV;
      else if (out_update)
         slow_sensor_sequence_counter <= mag_load ? seq_reload
            : slow_sensor_sequence_counter - 7'h01;
      else if (slow_sensor_sequence_counter > seq_reload)
         slow_sensor_sequence_counter <= seq_reload;
   end

   // slow sensor registers and their new-data flag
   // set beats read clear
   always_ff @(posedge mclk) begin
      if (srst) begin
         magnetometer_output_regs <= '0;
         pressure_output_reg      <= 16'h0000;
         mag_new_data             <= 1'b0;
      end else if (mag_load) begin
         magnetometer_output_regs <= slow_in.mag;
         pressure_output_reg      <= slow_in.baro;
         mag_new_data             <= 1'b1;
      end else if (slow_rd) begin
         mag_new_data <= 1'b0;
      end
   end

   // data ready goes invalid briefly after each output update
   always_ff @(posedge mclk) begin
      if (srst)
         inv_cnt <= '0;
      else if (dec_fire)
         inv_cnt <= 16'(DRDY_INVALID_CYC);
      else if (inv_cnt != 16'h0000)
         inv_cnt <= inv_cnt - 16'h0001;
   end
   assign drdy_valid = (inv_cnt == 16'h0000) && !dec_fire;
   assign dr_lvl = misc_control_reg[MISC_DR_POL] ? drdy_valid : !drdy_valid;

   // read data: output lines show the stored level, inputs the pin
   // level bits
   assign lvl_rd = (gpio_dir & gpio_lvl) | (~gpio_dir & pin_sync);
   always_comb begin
      rd_val  = 16'h0000;
      slow_rd = 1'b0;
      for (int i = 0; i < 3; i++) begin
         if (reg_req.addr == OFS_GYRO + 7'(2 * i))
            rd_val = gyro_output_regs[i];
         if (reg_req.addr == OFS_ACCEL + 7'(2 * i))
            rd_val = accel_output_regs[i];
         if (reg_req.addr == OFS_MAG + 7'(2 * i)) begin
            rd_val  = magnetometer_output_regs[i];
            slow_rd = reg_req.rd;
         end
         if (reg_req.addr == OFS_BIAS + 7'(2 * i))
            rd_val = gyro_bias[i];
      end
      if (reg_req.addr == OFS_BARO) begin
         rd_val  = pressure_output_reg;
         slow_rd = reg_req.rd;
      end
      if (reg_req.addr == OFS_TEMP)
         rd_val = temp_output_reg;
      if (reg_req.addr == OFS_GPIO)
         rd_val = {4'h0, lvl_rd, 4'h0, gpio_dir};
      if (reg_req.addr == OFS_MISC)
         rd_val = misc_control_reg;
      if (reg_req.addr == OFS_SMPL)
         rd_val = sample_period_control;
      if (reg_req.addr == OFS_AVG)
         rd_val = filter_and_range_control;
      if (reg_req.addr == OFS_SEQ)
         rd_val = {9'h000, slow_sensor_sequence_counter};
   end

   // registered read port, one cycle after the strobe
   always_ff @(posedge mclk) begin
      if (srst)
         reg_rdata <= 16'h0000;
      else if (reg_req.rd)
         reg_rdata <= rd_val;
   end

   // line ownership, highest claimant wins
   always_comb begin
      io_pins.out = gpio_lvl & gpio_dir;
      io_pins.oe  = gpio_dir;
      if (misc_control_reg[MISC_DR_EN] && !misc_control_reg[MISC_DR_SEL]) begin
         io_pins.out[0] = dr_lvl;
         io_pins.oe[0]  = 1'b1;
      end else if (alarm_drive[0]) begin
         io_pins.out[0] = alarm_level[0];
         io_pins.oe[0]  = 1'b1;
      end
      if (misc_control_reg[MISC_DR_EN] && misc_control_reg[MISC_DR_SEL]) begin
         io_pins.out[1] = dr_lvl;
         io_pins.oe[1]  = 1'b1;
      end else if (alarm_drive[1]) begin
         io_pins.out[1] = alarm_level[1];
         io_pins.oe[1]  = 1'b1;
      end
      if (!clk_int) begin
         io_pins.out[3] = 1'b0;
         io_pins.oe[3]  = 1'b0;
      end
   end

   property p_drdy_own;
      @(posedge mclk) disable iff (srst)
      misc_control_reg[MISC_DR_EN] && !misc_control_reg[MISC_DR_SEL]
      |-> io_pins.oe[0] && (io_pins.out[0] == dr_lvl);
   endproperty
   a_drdy_own: assert property (p_drdy_own)
      else $error("data ready lost line one");

   property p_alarm_own;
      @(posedge mclk) disable iff (srst)
      !(misc_control_reg[MISC_DR_EN] && misc_control_reg[MISC_DR_SEL])
      && alarm_drive[1]
      |-> io_pins.oe[1] && (io_pins.out[1] == alarm_level[1]);
   endproperty
   a_alarm_own: assert property (p_alarm_own)
      else $error("alarm did not drive line two");

   property p_ext_clk;
      @(posedge mclk) disable iff (srst)
      !clk_int |-> !io_pins.oe[3];
   endproperty
   a_ext_clk: assert property (p_ext_clk)
      else $error("line four driven in external clock mode");

   property p_line3;
      @(posedge mclk) disable iff (srst)
      io_pins.oe[2] == general_io_control[2]
      && io_pins.out[2] == (general_io_control[10] & general_io_control[2]);
   endproperty
   a_line3: assert property (p_line3)
      else $error("line three not under gpio control");

   property p_gpio_rst;
      @(posedge mclk)
      // line one is data ready by default, so only lines three, four
      $past(srst) |-> general_io_control == 16'h0000
      && io_pins.oe[3:2] == 2'h0;
   endproperty
   a_gpio_rst: assert property (p_gpio_rst)
      else $error("gpio not zero after reset");

   property p_seq_reload;
      @(posedge mclk) disable iff (srst)
      out_update && slow_sensor_sequence_counter == 7'h01
      && dec_d == 5'h00 |=> slow_sensor_sequence_counter == 7'h10;
   endproperty
   a_seq_reload: assert property (p_seq_reload)
      else $error("sequence counter did not reload sixteen");

   property p_new_data;
      @(posedge mclk) disable iff (srst)
      mag_load |=> mag_new_data && pressure_output_reg == $past(slow_in.baro);
   endproperty
   a_new_data: assert property (p_new_data)
      else $error("new data flag not set on slow load");

   property p_range_floor;
      @(posedge mclk) disable iff (srst)
      filter_and_range_control[10:8] == 3'h1
      |-> filter_and_range_control[2:0] >= 3'h4;
   endproperty
   a_range_floor: assert property (p_range_floor)
      else $error("250 range with fewer than sixteen taps");

   property p_unused_zero;
      @(posedge mclk) disable iff (srst)
      (general_io_control & 16'hF0F0) == 16'h0000
      && (sample_period_control & 16'hE0FE) == 16'h0000;
   endproperty
   a_unused_zero: assert property (p_unused_zero)
      else $error("unused bits became set");
endmodule : isf_filter_io

//--- sim/isf_host_model.sv
`timescale 1ns/1ps
module isf_host_model (
   // clock
   input  wire logic            mclk,
   // register access
   output isf_pkg::isf_reg_req_t reg_req,
   input  wire logic [15:0]     reg_rdata
);
   import isf_pkg::*;

   // idle bus at time zero, no strobe before reset ends
   initial reg_req = '0;

   // a strobe stands for exactly one sampling edge
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge mclk);
      reg_req.wr <= 1'b0;
   endtask : wr

   // data is taken at the edge after the one that registers it
   task automatic rd(input logic [6:0] a, output logic [15:0] d);
      @(posedge mclk);
      reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge mclk);
      reg_req.rd <= 1'b0;
      @(posedge mclk);
      d = reg_rdata;
   endtask : rd
endmodule : isf_host_model

//--- sim/isf_filter_io_tb.sv
`timescale 1ns/1ps
module isf_filter_io_tb;
   import isf_pkg::*;
   // short sample period, longer than the data ready window
   localparam int unsigned SPER = 40;
   logic          mclk        = 1'b0;
   logic          srst        = 1'b1;
   isf_reg_req_t  reg_req;
   logic [15:0]   reg_rdata;
   isf_inertial_t inertial_in = '0;
   isf_slow_t     slow_in     = '0;
   logic [1:0]    alarm_drive = 2'b00;
   logic [1:0]    alarm_level = 2'b00;
   logic [3:0]    io_in       = 4'h0;
   isf_pin_t      io_pins;
   logic          mag_new_data;
   logic          out_update;
   int            err_count   = 0;
   int            n_tests     = 0;
   int            cyc         = 0;
   int            g;

   always #5 mclk = ~mclk;

   isf_filter_io #(.SAMPLE_CYC_P(SPER)) dut (
      .mclk(mclk), .srst(srst), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .inertial_in(inertial_in), .slow_in(slow_in),
      .alarm_drive(alarm_drive), .alarm_level(alarm_level),
      .io_line_one_in(io_in[0]), .io_line_two_in(io_in[1]),
      .io_line_three_in(io_in[2]), .io_line_four_in(io_in[3]),
      .io_pins(io_pins), .mag_new_data(mag_new_data),
      .out_update(out_update));

   isf_host_model host (.mclk(mclk), .reg_req(reg_req),
      .reg_rdata(reg_rdata));

   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] s);
      n_tests++;
      if (s !== e) begin
         $display("Error %s expected %h seen %h", nm, e, s);
         err_count++;
      end
   endtask : chk

   task automatic rchk(input string nm, input logic [6:0] a,
                       input logic [15:0] e);
      logic [15:0] d;
      host.rd(a, d);
      chk(nm, e, d);
   endtask : rchk

   // cycles between two update pulses, bounded so a stall cannot hang
   task automatic gap(output int n);
      int i;
      for (i = 0; i < 400 && out_update !== 1'b1; i++) @(negedge mclk);
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (out_update !== 1'b1 && n < 400);
   endtask : gap

   task automatic t_reset;
      rchk("gpio", OFS_GPIO, 16'h0000);
      rchk("smpl", OFS_SMPL, 16'h0001);
      rchk("avg", OFS_AVG, 16'h0402);
      chk("oe", 16'h0001, {12'h000, io_pins.oe});
      chk("out", 16'h0001, {12'h000, io_pins.out});
   endtask : t_reset

   // alarm on line two drives low against a gpio level of one
   task automatic t_pins;
      @(posedge mclk) alarm_drive <= 2'b10;
      host.wr(OFS_GPIO, 16'hFFFF);
      rchk("gpio", OFS_GPIO, 16'h0F0F);
      chk("oe", 16'h000F, {12'h000, io_pins.oe});
      chk("out", 16'h0006, {13'h0, io_pins.out[3:1]});
      @(posedge mclk) alarm_drive <= 2'b00;
      host.wr(OFS_GPIO, 16'h0000);
   endtask : t_pins

   // first gap after a smpl write may be short, so take the second
   task automatic t_rate;
      gap(g);
      gap(g);
      chk("period", 16'(SPER), 16'(g));
      host.wr(OFS_SMPL, 16'h0101);
      gap(g);
      gap(g);
      chk("period_d1", 16'(2 * SPER), 16'(g));
      host.wr(OFS_SMPL, 16'h0001);
   endtask : t_rate

   // range 250 and filter size zero go in one write, then b floor is seen
   task automatic t_range;
      host.wr(OFS_AVG, 16'h0100);
      rchk("avg", OFS_AVG, 16'h0104);
      host.wr(OFS_AVG, 16'h0402);
   endtask : t_range

   // constant input settles through both stages, bias adds on top
   task automatic t_bias;
      host.wr(OFS_BIAS, 16'h0005);
      repeat (12) gap(g);
      rchk("gyro_x", OFS_GYRO, 16'h0105);
   endtask : t_bias

   // clear the flag first so the check lands just after a fresh load
   task automatic t_slow;
      int i;
      @(posedge mclk) slow_in.baro <= 16'h0BA0;
      rchk("mag_x", OFS_MAG, 16'h0000);
      for (i = 0; i < 800 && mag_new_data !== 1'b1; i++) @(negedge mclk);
      chk("new_data", 16'h0001, {15'h0, mag_new_data});
      rchk("seq", OFS_SEQ, 16'h0010);
      rchk("baro", OFS_BARO, 16'h0BA0);
      chk("new_data", 16'h0000, {15'h0, mag_new_data});
   endtask : t_slow

   // host clears clock bit and line four direction for external clock
   task automatic t_ext;
      @(posedge mclk) io_in <= 4'b0100;
      host.wr(OFS_SMPL, 16'h0000);
      host.wr(OFS_GPIO, 16'h0003);
      @(negedge mclk);
      chk("oe", 16'h0003, {12'h000, io_pins.oe});
      rchk("gpio", OFS_GPIO, 16'h0403);
      // a rising edge on line four every twenty cycles
      fork
         repeat (6) begin
            repeat (10) @(posedge mclk);
            io_in[3] <= ~io_in[3];
         end
         begin
            gap(g);
            gap(g);
         end
      join
      chk("ext_period", 16'h0014, 16'(g));
   endtask : t_ext

   task automatic results;
      $display("errors %0d checks %0d", err_count, n_tests);
      if (err_count == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : results

   // a hang counts as a mismatch
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_count++;
         results();
      end
   end

   initial begin
      inertial_in.gyro[0] = 16'h0100;
      repeat (12) @(posedge mclk);
      srst <= 1'b0;
      t_reset();
      t_pins();
      t_rate();
      t_range();
      t_bias();
      t_slow();
      t_ext();
      results();
   end
endmodule : isf_filter_io_tb
